// [pkg/sahp_pkg.sv]
// Constants, field layout and carrier types of the simultaneous ADC host port.
// Assumes one 20 MHz clock; host pins are asynchronous and are synchronised.
package sahp_pkg;
  // ----------------------------------------------------------------
  // Setup register layout
  // ----------------------------------------------------------------
  localparam int          SETUP_W       = 4;        // Setup register width
  localparam int          BIT_REF       = 3;        // Reference source
  localparam int          BIT_FMT       = 2;        // Result format
  localparam int          BIT_RSVD      = 1;        // Reserved, written zero
  localparam int          BIT_MODE      = 0;        // Sampling mode
  localparam logic [3:0]  SETUP_RESET   = 4'h0;     // Power-on value
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 20000000; // ref_clk rate
  localparam int          CONV_TIME_NS  = 3000;     // Conversion time
  localparam int          CONV_CYCLES   = CONV_TIME_NS / 50; // Round down at 50ns period
  localparam int          SYNC_STAGES   = 3;        // Pin synchroniser depth
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAHP_TRACK = 2'b00,  // Inputs tracked
    SAHP_HOLD  = 2'b01,  // Held, waiting for acquisition request
    SAHP_CONV  = 2'b10   // Converting
  } sahp_state_t;
  typedef struct packed {
    logic cs;   // Chip select, synchronised, active low level
    logic rd;   // Read strobe, synchronised
    logic wr;   // Write strobe, synchronised
    logic trig; // Sample trigger, synchronised
  } sahp_pins_t;
endpackage

// [src/sahp_host_port.sv]
// Host port and conversion control of a simultaneous-sampling converter.
// Assumes sample words arrive on sampleIn from the analog front end and
// that the testbench resolves the shared bus from resultBusOe.
`timescale 1ns/1ns
module sahp_host_port
  import sahp_pkg::*;
#(
  parameter int CHANNELS   = 8,  // Implemented channels: 4, 6 or 8
  parameter int RESULT_W   = 16, // 16 wide variant, 14 narrow
  parameter int CONV_COUNT = CONV_CYCLES
)(
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire logic                         csN,
  input  wire logic                         rdN,
  input  wire logic                         wrN,
  input  wire logic                         sample_trigger,
  input  wire logic                         power_down_input,
  input  wire logic [RESULT_W-1:0]          resultBusIn,
  output logic      [RESULT_W-1:0]          resultBusOut,
  output logic      [RESULT_W-1:0]          resultBusOe,
  input  wire logic [CHANNELS*RESULT_W-1:0] sampleIn,
  output logic                              convDoneN,
  output logic                              trackEn,
  output logic                              ref_source_bit,
  output logic                              result_format_bit,
  output logic                              lowPower
);
  localparam int PW = $clog2(CHANNELS);
  localparam int CW = $clog2(CONV_COUNT + 1);
  localparam int CB0 = RESULT_W - SETUP_W; // Setup bits ride the top four bus lines
  localparam int CONV_WAIT = CONV_COUNT - 1; // Cycles from first count to last count
  localparam logic [PW-1:0] LAST_CH = PW'(CHANNELS - 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_COUNT - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sahp_pins_t                  s2;      // Second sync stage
    sahp_pins_t                  s3;      // Third sync stage
    sahp_pins_t                  pin;     // Agreed pin levels
    sahp_state_t                 fsm;     // Conversion state
    logic [CW-1:0]               cnt;     // Conversion cycle counter
    logic [SETUP_W-1:0]          setup;   // Setup register
    logic [CHANNELS*RESULT_W-1:0] hold;   // Held samples
    logic [PW-1:0]               ptr;     // Readout channel
    logic [RESULT_W-1:0]         dout;    // Word on the bus
    logic                        doneN;   // Conversion done, active low
    logic                        pdS2;    // Power-down second sync stage
    logic                        pdS3;    // Power-down third sync stage
    logic                        pdPin;   // Agreed power-down level
  } sahp_st_t;

  sahp_st_t   st;       // Registered state
  sahp_st_t   next_st;  // Next state
  sahp_pins_t s1;       // First sync stage, read only by s2
  logic       pdS1;     // Power-down first stage, read only by pdS2
  logic       wrRise;   // Write strobe rising edge
  logic       rdRise;   // Read strobe rising edge
  logic       trigRise; // Trigger rising edge
  logic       busOn;    // Device drives the bus
  logic [RESULT_W-1:0] rawWord;   // Selected channel word
  logic [RESULT_W-1:0] fmtWord;   // Word after encoding

  // ----------------------------------------------------------------
  // First synchroniser stage, kept apart so nothing else reads it
  // ----------------------------------------------------------------
  // Limitation: a pin level must stand two clocks to count, so a trigger
  // low shorter than that is filtered out rather than taken as a start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1   <= '1;
      pdS1 <= 1'b0; // Power-down idles low
    end else begin
      s1   <= '{cs: csN, rd: rdN, wr: wrN, trig: sample_trigger};
      pdS1 <= power_down_input;
    end
  end

  // Edges taken only once stages two and three agree
  assign wrRise   = (st.s2.wr == st.s3.wr) && st.s3.wr && !st.pin.wr;
  assign rdRise   = (st.s2.rd == st.s3.rd) && st.s3.rd && !st.pin.rd;
  assign trigRise = (st.s2.trig == st.s3.trig) && st.s3.trig && !st.pin.trig;

  // Channel word and encoding; two's complement flips the top bit
  assign rawWord = st.hold[st.ptr*RESULT_W +: RESULT_W];
  assign fmtWord = st.setup[BIT_FMT] ? {~rawWord[RESULT_W-1], rawWord[RESULT_W-2:0]}
                                     : rawWord;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.s2   = s1;
    next_st.s3   = st.s2;
    // Agreed level follows stages two and three only when they match
    if (st.s2.cs == st.s3.cs) next_st.pin.cs = st.s3.cs;
    if (st.s2.rd == st.s3.rd) next_st.pin.rd = st.s3.rd;
    if (st.s2.wr == st.s3.wr) next_st.pin.wr = st.s3.wr;
    if (st.s2.trig == st.s3.trig) next_st.pin.trig = st.s3.trig;
    // Power-down pin passes the same three-stage filter
    next_st.pdS2 = pdS1;
    next_st.pdS3 = st.pdS2;
    if (st.pdS2 == st.pdS3) next_st.pdPin = st.pdS3;
    // Setup is taken on the write rising edge while selected, also in power-down
    if (wrRise && !st.pin.cs) begin
      next_st.setup = resultBusIn[CB0 +: SETUP_W];
    end
    // Readout advances once per completed read strobe
    if (rdRise && !st.pin.cs) begin
      next_st.ptr = (st.ptr == LAST_CH) ? '0 : st.ptr + 1'b1;
    end
    next_st.dout = fmtWord;
    case (st.fsm)
      SAHP_TRACK: begin
        // Trigger rise freezes every channel in the same cycle
        if (trigRise && !st.pdPin) begin
          next_st.hold  = sampleIn;
          next_st.fsm   = SAHP_CONV;
          next_st.cnt   = '0;
          next_st.doneN = 1'b1;
          next_st.ptr   = '0;
        end
      end
      SAHP_HOLD: begin
        // Mode 0 waits for trigger low before tracking again
        if (st.setup[BIT_MODE] || !st.pin.trig) begin
          next_st.fsm = SAHP_TRACK;
        end
      end
      SAHP_CONV: begin
        if (st.cnt == CONV_LAST) begin
          next_st.doneN = 1'b0;
          next_st.fsm   = st.setup[BIT_MODE] ? SAHP_TRACK : SAHP_HOLD;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.fsm = SAHP_TRACK;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= '0;
      st.s2    <= '1;
      st.s3    <= '1;
      st.pin   <= '1;
      st.fsm   <= SAHP_TRACK;
      st.setup <= SETUP_RESET;
      st.doneN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus is driven only while select and read strobe are agreed low; pins are
  // synchronised, so release lags the pin by up to four cycles
  assign busOn             = !st.pin.cs && !st.pin.rd;
  assign resultBusOe       = {RESULT_W{busOn}};
  assign resultBusOut      = st.dout;
  assign convDoneN         = st.doneN;
  assign trackEn           = (st.fsm == SAHP_TRACK) && !st.pdPin;
  assign ref_source_bit    = st.setup[BIT_REF];
  assign result_format_bit = st.setup[BIT_FMT];
  assign lowPower          = st.pdPin;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_conv_start;
    trigRise && st.fsm == SAHP_TRACK && !st.pdPin;
  endsequence
  property p_bus_off;
    @(posedge ref_clk) disable iff (!rstn) (st.pin.cs || st.pin.rd) |-> resultBusOe == '0;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus driven while idle");
  property p_done_high;
    @(posedge ref_clk) disable iff (!rstn) (st.fsm == SAHP_CONV) |-> convDoneN;
  endproperty
  a_done_high: assert property (p_done_high) else $error("done low during conversion");
  property p_conv_len;
    @(posedge ref_clk) disable iff (!rstn)
      s_conv_start |=> ##CONV_WAIT (st.fsm == SAHP_CONV) ##1 !convDoneN;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_hold_all;
    @(posedge ref_clk) disable iff (!rstn) s_conv_start |=> st.hold == $past(sampleIn);
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("samples not held together");
  property p_ptr_zero;
    @(posedge ref_clk) disable iff (!rstn) s_conv_start |=> st.ptr == '0;
  endproperty
  a_ptr_zero: assert property (p_ptr_zero) else $error("pointer not reset");
  property p_ptr_step;
    @(posedge ref_clk) disable iff (!rstn)
      (rdRise && !st.pin.cs && st.ptr != LAST_CH
       && !(trigRise && st.fsm == SAHP_TRACK && !st.pdPin))
      |=> st.ptr == $past(st.ptr) + 1'b1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");
  property p_setup_load;
    @(posedge ref_clk) disable iff (!rstn)
      (wrRise && !st.pin.cs) |=> st.setup == $past(resultBusIn[CB0 +: SETUP_W]);
  endproperty
  a_setup_load: assert property (p_setup_load) else $error("setup not loaded");
  property p_setup_keep;
    @(posedge ref_clk) disable iff (!rstn) !(wrRise && !st.pin.cs) |=> $stable(st.setup);
  endproperty
  a_setup_keep: assert property (p_setup_keep) else $error("setup changed");
  property p_mode1_track;
    @(posedge ref_clk) disable iff (!rstn)
      (st.fsm == SAHP_CONV && st.cnt == CONV_LAST && st.setup[BIT_MODE])
      |=> st.fsm == SAHP_TRACK;
  endproperty
  a_mode1_track: assert property (p_mode1_track) else $error("no auto acquisition");
  property p_mode0_wait;
    @(posedge ref_clk) disable iff (!rstn)
      (st.fsm == SAHP_HOLD && !st.setup[BIT_MODE] && st.pin.trig) |=> st.fsm == SAHP_HOLD;
  endproperty
  a_mode0_wait: assert property (p_mode0_wait) else $error("tracked before trigger low");
  // Power-down must block any new conversion while the setup is kept
  property p_pd_block;
    @(posedge ref_clk) disable iff (!rstn)
      (st.fsm == SAHP_TRACK && st.pdPin) |=> st.fsm == SAHP_TRACK;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("conversion in power-down");
endmodule

// [verification/sahp_host_model.sv]
// Host-side model of the parallel port: strobes, trigger and setup lines.
// Assumes the bench resolves the shared bus and returns it on busIn.
`timescale 1ns/1ns
module sahp_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] busIn,
  input  wire logic [15:0] devOe,
  output logic             csN,
  output logic             rdN,
  output logic             wrN,
  output logic             trig,
  output logic [15:0]      busOut,
  output logic             busOe
);
  initial begin
    {csN, rdN, wrN, trig, busOe} = 5'h1E;
    busOut = 16'h0000;
  end
  // ----------------------------------------------------------------
  // Host cycles, all launched at the falling edge
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Setup write; the reserved position always goes out as zero
  task automatic wrSetup(input logic [3:0] v);
    csN = 1'b0;
    wrN = 1'b0;
    busOe = 1'b1;
    busOut = {v[3:2], 1'b0, v[0], 12'h000};
    tick(6);
    wrN = 1'b1;
    tick(6);
    csN = 1'b1;
    busOe = 1'b0;
    tick(12);
  endtask
  // One read pulse; bus lines released first so the device owns them
  task automatic rdWord(input bit keepCs, output logic [15:0] w, output logic oeOn,
                        output logic oeOff);
    busOe = 1'b0;
    csN = 1'b0;
    rdN = 1'b0;
    tick(6);
    w = busIn;
    oeOn = &devOe;
    rdN = 1'b1;
    tick(6);
    oeOff = |devOe;
    csN = !keepCs;
    tick(4); // Released select stands long enough to pass the filter
  endtask
  // Trigger low for n cycles, then a rising edge
  task automatic pulse(input int n);
    trig = 1'b0;
    tick(n);
    trig = 1'b1;
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench of the host port with an 8-channel 16-bit build.
// Assumes the design shortens conversion through CONV_COUNT.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nErrors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench
  import sahp_pkg::*;
;
  localparam int CONV = 4;  // Short conversion to keep the run brief
  logic          ref_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          pd = 1'b0;
  logic [127:0]  sampleIn = '0;
  logic [15:0]   lastBus = 16'h0000;
  logic [15:0]   bus;       // Resolved shared bus
  logic [15:0]   devOut;    // Word the design offers
  logic [15:0]   devOe;     // Design bus enables
  logic [15:0]   hostOut;   // Word the host offers
  logic          csN;       // Host chip select
  logic          rdN;       // Host read strobe
  logic          wrN;       // Host write strobe
  logic          trig;      // Sample trigger
  logic          hostOe;    // Host drives the bus
  logic          doneN;     // Conversion done
  logic          trackEn;   // Inputs tracking
  logic          refBit;    // Reference select
  logic          fmtBit;    // Result format
  logic          lowPower;  // Power-down state
  int            nErrors = 0;
  int            numChecks = 0;
  // Undriven lines show a changing pattern, never a stale value
  assign bus = (devOe & devOut) | (~devOe & (hostOe ? hostOut : ~lastBus));
  always @(posedge ref_clk) lastBus <= bus;
  always #25 ref_clk = ~ref_clk;
  sahp_host_model u_host (
    .ref_clk (ref_clk),
    .busIn   (bus),
    .devOe   (devOe),
    .csN     (csN),
    .rdN     (rdN),
    .wrN     (wrN),
    .trig    (trig),
    .busOut  (hostOut),
    .busOe   (hostOe)
  );
  sahp_host_port #(.CHANNELS(8), .RESULT_W(16), .CONV_COUNT(CONV)) u_dut (
    .ref_clk           (ref_clk),
    .rstn              (rstn),
    .csN               (csN),
    .rdN               (rdN),
    .wrN               (wrN),
    .sample_trigger    (trig),
    .power_down_input  (pd),
    .resultBusIn       (bus),
    .resultBusOut      (devOut),
    .resultBusOe       (devOe),
    .sampleIn          (sampleIn),
    .convDoneN         (doneN),
    .trackEn           (trackEn),
    .ref_source_bit    (refBit),
    .result_format_bit (fmtBit),
    .lowPower          (lowPower)
  );
  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic test_done;
    if (nErrors == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One conversion and a nine-read readout checked against a queue model
  task automatic runConv(input logic [3:0] s, input bit keepCs, input int lowN);
    logic [15:0] w;
    logic        on, off;
    int          n;
    logic [15:0] q[$];
    for (int i = 0; i < 8; i++) sampleIn[i*16 +: 16] = 16'($urandom);
    u_host.pulse(lowN);
    `CHK("trackEn", 1'b1, trackEn)
    for (int i = 0; i < 8; i++) q.push_back(sampleIn[i*16 +: 16] ^ {s[2], 15'h0000});
    u_host.tick(5);
    `CHK("busy", 1'b1, doneN)
    `CHK("hold", 1'b0, trackEn)
    sampleIn = {4{$urandom}}; // Moving inputs must not reach held results
    n = 5;
    while (doneN !== 1'b0 && n < 100) begin
      u_host.tick(1);
      n++;
    end
    `CHK("convTime", 1'b1, n >= CONV && n <= CONV + 10)
    u_host.tick(2);
    `CHK("reTrack", s[0], trackEn)
    for (int i = 0; i < 9; i++) begin
      u_host.rdWord(keepCs, w, on, off);
      `CHK("word", q[i % 8], w)
      `CHK("oeOn", 1'b1, on)
      `CHK("oeOff", 1'b0, off)
    end
    u_host.rdWord(1'b0, w, on, off);
    u_host.tick(12);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5813));
    u_host.tick(10);
    rstn = 1'b1;
    u_host.tick(4);
    `CHK("resetBits", 3'b100, {doneN, refBit, fmtBit})
    u_host.wrSetup(4'h8);
    `CHK("setup", 2'b10, {refBit, fmtBit})
    runConv(4'h8, 1'b1, 21);
    u_host.wrSetup(4'h4);
    `CHK("setup", 2'b01, {refBit, fmtBit})
    runConv(4'h4, 1'b0, 21);
    u_host.wrSetup(4'h5);
    `CHK("setup", 2'b01, {refBit, fmtBit})
    // Trigger low of three clocks: two are the least the pin filter takes
    runConv(4'h5, 1'b0, 3);
    runConv(4'h5, 1'b1, 3);
    pd = 1'b1;
    u_host.tick(4);
    u_host.pulse(2);
    u_host.tick(5);
    `CHK("pdIdle", 3'b010, {doneN, lowPower, trackEn})
    u_host.tick(30);
    `CHK("pdKeep", 2'b01, {refBit, fmtBit})
    pd = 1'b0;
    rstn = 1'b0;
    u_host.tick(2);
    rstn = 1'b1;
    u_host.tick(2);
    `CHK("reReset", 3'b100, {doneN, refBit, fmtBit})
    test_done;
  end
  // Watchdog: the sequence needs about 900 cycles
  initial begin
    #(20000 * 50);
    nErrors++;
    test_done;
  end
endmodule
